/* pkg/flash_seq_pkg.sv */
/*
 * Package for the flash word write sequencer: geometry, timing, states, carriers.
 * Assumes a 10 MHz system clock; all timing counts derive from it.
 */
package flash_seq_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned WORD_ADDR_W     = 16;
    localparam int unsigned PAGE_NUM_W      = 7;
    localparam int unsigned PAGE_COUNT      = 128;
    localparam int unsigned PAGE_BYTES      = 2048;
    localparam int unsigned WORDS_PER_PAGE  = PAGE_BYTES / 4;
    localparam int unsigned PAGE_LSB        = 1;
    localparam int unsigned PAGE_MSB        = 7;
    localparam int unsigned BYTE_DEADLINE_US = 20;
    localparam int unsigned WORD_PROG_US    = 20;
    localparam int unsigned PAGE_ERASE_MS   = 20;
    localparam int unsigned CHIP_ERASE_MS   = 20;
    // Deadline is a longest time: round down; program is a least time: round up; erase counts truncate CLK_HZ/1000
    localparam int unsigned DEADLINE_CYC    = BYTE_DEADLINE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned PROG_CYC        = (WORD_PROG_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int unsigned PAGE_ERASE_CYC  = (PAGE_ERASE_MS * (CLK_HZ / 1000));
    localparam int unsigned CHIP_ERASE_CYC  = (CHIP_ERASE_MS * (CLK_HZ / 1000));
    localparam logic [1:0]  BYTE_IDX_RESET  = 2'h0;
    localparam logic [31:0] ERASED_WORD     = 32'hFFFFFFFF;

    typedef enum {
        ST_IDLE,
        ST_ERASE,
        ST_FILL,
        ST_PROGRAM
    } seq_state_t;

    typedef struct packed {
        logic                    write;
        logic                    erase;
        logic                    chip_erase;
    } start_cmd_t;

    typedef struct packed {
        logic                    busy;
        logic                    write;
        logic                    full;
        logic                    abort;
        logic                    timeout;
    } flash_status_t;
endpackage

/* rtl/flash_array_mem.sv */
/*
 * Flash array model: word memory with masked programming and page/chip erase.
 * Assumes one operation per cycle; read data are registered.
 */
`timescale 1ns/1ps
module flash_array_mem #(
    parameter int unsigned ADDR_W     = 16,
    parameter int unsigned PAGE_W     = 7,
    parameter int unsigned PAGE_WORDS = 512
) (
    input  wire logic              sys_clk,     // System clock
    input  wire logic              prog_en,     // Program one word
    input  wire logic [ADDR_W-1:0] prog_addr,   // Word address to program
    input  wire logic [31:0]       prog_data,   // Zero bits clear the cell
    input  wire logic              erase_en,    // Erase one page
    input  wire logic [PAGE_W-1:0] erase_page,  // Page to erase
    input  wire logic              chip_en,     // Erase every page
    input  wire logic [ADDR_W-1:0] rd_addr,     // Word read address
    output logic      [31:0]       rd_data      // Registered read data
);
    localparam int unsigned DEPTH = (1 << PAGE_W) * PAGE_WORDS;
    localparam int unsigned OFS_W = $clog2(PAGE_WORDS);

    logic [31:0] cells [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (chip_en) begin
            for (int i = 0; i < DEPTH; i++) begin
                cells[i] <= 32'hFFFFFFFF;
            end
        end else if (erase_en) begin
            for (int j = 0; j < PAGE_WORDS; j++) begin
                cells[{erase_page, OFS_W'(j)}] <= 32'hFFFFFFFF;
            end
        end else if (prog_en && (32'(prog_addr) < DEPTH)) begin
            cells[prog_addr] <= cells[prog_addr] & prog_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (32'(rd_addr) < DEPTH) begin
            rd_data <= cells[rd_addr];
        end else begin
            rd_data <= 32'hFFFFFFFF;
        end
    end
endmodule // flash_array_mem

/* rtl/flash_word_write_sequencer.sv */
/*
 * Flash word write sequencer: buffers four bytes per word, programs, erases pages.
 * Assumes synchronous plain-port control from a CPU or DMA channel in the same clock.
 */
`timescale 1ns/1ps
module flash_word_write_sequencer #(
    parameter int unsigned PAGE_ERASE_CYC = flash_seq_pkg::PAGE_ERASE_CYC,
    parameter int unsigned CHIP_ERASE_CYC = flash_seq_pkg::CHIP_ERASE_CYC,
    parameter int unsigned PAGE_W         = flash_seq_pkg::PAGE_NUM_W,
    parameter int unsigned PAGE_WORDS     = flash_seq_pkg::WORDS_PER_PAGE
) (
    input  wire logic                        sys_clk,            // System clock
    input  wire logic                        sys_rst,            // Sync reset, high
    input  wire logic [7:0]                  word_address_high,  // Address high byte
    input  wire logic [7:0]                  word_address_low,   // Address low byte
    input  wire flash_seq_pkg::start_cmd_t   start_cmd,          // One-cycle start strobes
    input  wire logic                        byte_wr,            // Write-data port strobe
    input  wire logic [7:0]                  flash_write_byte_port, // Write-data byte
    input  wire logic                        page_lock,          // Not used; tie low
    input  wire logic [127:0]                lock_mask,          // One per page, 1 = locked
    input  wire logic                        abort_clr,          // Clears abort flag
    input  wire logic [15:0]                 rd_word_addr,       // Processor word read address
    output flash_seq_pkg::flash_status_t     flash_control_status, // Status flags
    output logic                             dma_trigger,        // Port ready for a byte
    output logic                             fetch_block,        // Array unavailable for fetch
    output logic [31:0]                      rd_word             // Registered read data
);
    // Counter must span the longest erase as well as the program and deadline counts
    localparam int unsigned CNT_W = $clog2(PAGE_ERASE_CYC + CHIP_ERASE_CYC
                                           + flash_seq_pkg::PROG_CYC
                                           + flash_seq_pkg::DEADLINE_CYC + 2);

    flash_seq_pkg::seq_state_t state;
    logic [15:0]      word_addr;
    logic [31:0]      fill_buf;
    logic [31:0]      prog_buf;
    logic [1:0]       byte_idx;
    logic             full;
    logic             write_req;
    logic             chip_mode;
    logic             abort;
    logic             timeout;
    logic [CNT_W-1:0] op_cnt;
    logic [CNT_W-1:0] dl_cnt;
    logic [6:0]       erase_page;

    function automatic logic page_locked(input logic [15:0] addr, input logic [127:0] m);
        page_locked = m[addr[15:9]];
    endfunction

    wire logic writing   = (state == flash_seq_pkg::ST_FILL)
                         || (state == flash_seq_pkg::ST_PROGRAM);
    wire logic busy      = (state != flash_seq_pkg::ST_IDLE);
    wire logic last_byte = byte_wr && writing && !full && (byte_idx == 2'h3);
    wire logic deadline  = writing && !full
                         && (dl_cnt >= CNT_W'(flash_seq_pkg::DEADLINE_CYC));
    wire logic prog_done = (state == flash_seq_pkg::ST_PROGRAM)
                         && (op_cnt == CNT_W'(flash_seq_pkg::PROG_CYC - 1));

    ////////////////////////////////////////////////////////////////////////////
    // Sequence state
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state     <= flash_seq_pkg::ST_IDLE;
            write_req <= 1'b0;
            chip_mode <= 1'b0;
            op_cnt    <= '0;
            word_addr <= '0;
            erase_page <= '0;
        end else begin
            op_cnt <= op_cnt + 1'b1;
            case (state)
                flash_seq_pkg::ST_IDLE: begin
                    op_cnt <= '0;
                    word_addr  <= {word_address_high, word_address_low};
                    erase_page <= word_address_high[flash_seq_pkg::PAGE_MSB:
                                                    flash_seq_pkg::PAGE_LSB];
                    if (start_cmd.erase || start_cmd.chip_erase) begin
                        state     <= flash_seq_pkg::ST_ERASE;
                        chip_mode <= start_cmd.chip_erase;
                        write_req <= start_cmd.write;
                    end else if (start_cmd.write) begin
                        state <= flash_seq_pkg::ST_FILL;
                    end
                end
                flash_seq_pkg::ST_ERASE: begin
                    if (op_cnt == CNT_W'((chip_mode ? CHIP_ERASE_CYC : PAGE_ERASE_CYC) - 1)) begin
                        op_cnt    <= '0;
                        write_req <= 1'b0;
                        state     <= write_req ? flash_seq_pkg::ST_FILL
                                               : flash_seq_pkg::ST_IDLE;
                    end
                end
                flash_seq_pkg::ST_FILL: begin
                    op_cnt <= '0;
                    if (deadline) begin
                        state <= flash_seq_pkg::ST_IDLE;
                    end else if (full && page_locked(word_addr, lock_mask)) begin
                        state <= flash_seq_pkg::ST_IDLE;
                    end else if (full) begin
                        state <= flash_seq_pkg::ST_PROGRAM;
                    end
                end
                flash_seq_pkg::ST_PROGRAM: begin
                    if (prog_done) begin
                        word_addr <= word_addr + 16'h0001;
                        op_cnt    <= '0;
                        if (deadline) begin
                            state <= flash_seq_pkg::ST_IDLE;
                        end else if (full && page_locked(word_addr + 16'h0001, lock_mask)) begin
                            state <= flash_seq_pkg::ST_IDLE;
                        end else if (full) begin
                            state <= flash_seq_pkg::ST_PROGRAM;
                        end else begin
                            state <= flash_seq_pkg::ST_FILL;
                        end
                    end
                end
                default: state <= flash_seq_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Byte buffer and full flag
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fill_buf <= flash_seq_pkg::ERASED_WORD;
            prog_buf <= flash_seq_pkg::ERASED_WORD;
            byte_idx <= flash_seq_pkg::BYTE_IDX_RESET;
            full     <= 1'b0;
        end else begin
            if (!writing) begin
                byte_idx <= flash_seq_pkg::BYTE_IDX_RESET;
                full     <= 1'b0;
            end else if (byte_wr && !full) begin
                fill_buf[8*byte_idx +: 8] <= flash_write_byte_port;
                byte_idx <= byte_idx + 2'h1;
                full     <= last_byte;
            end else if (full && ((state == flash_seq_pkg::ST_FILL) || prog_done)) begin
                prog_buf <= fill_buf;
                full     <= 1'b0;
            end
        end
    end

    // Deadline counter restarts at write start and each time full falls
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !writing || full) begin
            dl_cnt <= '0;
        end else if (dl_cnt < CNT_W'(flash_seq_pkg::DEADLINE_CYC)) begin
            dl_cnt <= dl_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Abort and timeout flags; a new abort wins over the clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            abort   <= 1'b0;
            timeout <= 1'b0;
        end else begin
            if (writing && full && page_locked(state == flash_seq_pkg::ST_FILL
                    ? word_addr : word_addr + 16'h0001, lock_mask)
                    && ((state == flash_seq_pkg::ST_FILL) || prog_done)) begin
                abort <= 1'b1;
            end else if (abort_clr) begin
                abort <= 1'b0;
            end
            if (deadline) begin
                timeout <= 1'b1;
            end else if (start_cmd.write) begin
                timeout <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array
    // masked program, page and chip erase
    flash_array_mem #(
        .ADDR_W     (flash_seq_pkg::WORD_ADDR_W),
        .PAGE_W     (PAGE_W),
        .PAGE_WORDS (PAGE_WORDS)
    ) u_array (
        .sys_clk    (sys_clk),
        .prog_en    (prog_done),
        .prog_addr  (word_addr),
        .prog_data  (prog_buf),
        .erase_en   ((state == flash_seq_pkg::ST_ERASE) && !chip_mode && (op_cnt == '0)),
        .erase_page (erase_page),
        .chip_en    ((state == flash_seq_pkg::ST_ERASE) && chip_mode && (op_cnt == '0)),
        .rd_addr    (rd_word_addr),
        .rd_data    (rd_word)
    );

    assign flash_control_status.busy    = busy;
    assign flash_control_status.write   = writing || write_req;
    assign flash_control_status.full    = full;
    assign flash_control_status.abort   = abort;
    assign flash_control_status.timeout = timeout;
    // trigger when port can take data
    assign dma_trigger = writing && !full;
    assign fetch_block = busy;
endmodule // flash_word_write_sequencer

/* verification/flash_seq_monitor.sv */
/* Checker for the flash word write sequencer handshake and status flags.
   Assumes it is bound to the sequencer top and sees one clock domain. */
`timescale 1ns/1ps
module flash_seq_monitor (
    input wire logic                         sys_clk,              // System clock
    input wire logic                         sys_rst,              // Sync reset, high
    input wire flash_seq_pkg::start_cmd_t    start_cmd,            // Start strobes
    input wire logic                         byte_wr,              // Byte strobe
    input wire flash_seq_pkg::flash_status_t flash_control_status, // Status flags
    input wire logic                         dma_trigger,          // Port ready
    input wire logic                         fetch_block           // Fetch blocked
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    AST_DMA_READY: assert property ($fell(flash_control_status.full)
        && flash_control_status.busy |-> dma_trigger)
        else $error("dma trigger low after buffer freed");
    AST_FETCH_BLOCK: assert property (flash_control_status.write |-> fetch_block)
        else $error("fetch not blocked during write");
    AST_WRITE_START: assert property (start_cmd.write && !start_cmd.erase
        && !flash_control_status.busy
        |=> flash_control_status.busy && flash_control_status.write)
        else $error("write start not taken");
    AST_ERASE_HOLD: assert property (start_cmd.erase && !flash_control_status.busy
        |=> flash_control_status.busy [*8])
        else $error("busy dropped during erase");
    AST_FULL_CAUSE: assert property ($rose(flash_control_status.full)
        |-> $past(byte_wr && dma_trigger))
        else $error("full rose without a byte");
    AST_FULL_DROP: assert property ($rose(flash_control_status.full)
        |-> ##[1:201] !flash_control_status.full)
        else $error("full stuck high");
    AST_TIMEOUT_END: assert property ($rose(flash_control_status.timeout)
        |-> !flash_control_status.busy && !flash_control_status.write)
        else $error("timeout with busy or write");
    AST_ABORT_END: assert property ($rose(flash_control_status.abort)
        |-> !flash_control_status.busy && !flash_control_status.write)
        else $error("abort with busy or write");
endmodule // flash_seq_monitor

bind flash_word_write_sequencer flash_seq_monitor u_flash_seq_monitor (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .start_cmd(start_cmd), .byte_wr(byte_wr),
    .flash_control_status(flash_control_status), .dma_trigger(dma_trigger),
    .fetch_block(fetch_block));

/* verification/byte_writer_model.sv */
/* Writer model: feeds word bytes to the write-data port on each DMA trigger.
   Assumes inputs change at the falling edge; gap adds idle cycles per byte. */
`timescale 1ns/1ps
module byte_writer_model (
    input  wire logic        sys_clk,     // System clock
    input  wire logic        en,          // Feed bytes while high
    input  wire logic [31:0] word,        // Word to send
    input  wire logic [7:0]  gap,         // Idle cycles before each byte
    input  wire logic        dma_trigger, // Port ready
    output logic             byte_wr,     // Byte strobe
    output logic [7:0]       wr_byte      // Byte value
);
    logic [1:0] idx;
    logic [7:0] wait_cnt;
    // low byte first, only when ready; idle data shows the inverse
    always @(negedge sys_clk) begin
        if (en && dma_trigger && wait_cnt >= gap) begin
            byte_wr  <= 1'b1;
            wr_byte  <= word[idx*8 +: 8];
            idx      <= idx + 2'h1;
            wait_cnt <= 8'h00;
        end else begin
            byte_wr  <= 1'b0;
            wr_byte  <= ~word[idx*8 +: 8];
            idx      <= en ? idx : 2'h0;
            wait_cnt <= !en ? 8'h00 : (dma_trigger ? wait_cnt + 8'h01 : wait_cnt);
        end
    end
endmodule // byte_writer_model

/* verification/tb_top.sv */
/* Testbench for the flash word write sequencer with a byte writer model.
   Assumes a 10 MHz clock and short erase counts for simulation. */
`timescale 1ns/1ps
module tb_top;
    logic                         sys_clk = 1'b0;
    logic                         sys_rst = 1'b1;
    logic [7:0]                   addr_hi = 8'h02;
    logic [7:0]                   addr_lo = 8'h10;
    flash_seq_pkg::start_cmd_t    start_cmd = '0;
    logic                         byte_wr;
    logic [7:0]                   wr_byte;
    logic [127:0]                 lock_mask = '0;
    logic                         abort_clr = 1'b0;
    logic [15:0]                  rd_word_addr = 16'h0000;
    flash_seq_pkg::flash_status_t st;
    logic                         dma_trigger, fetch_block, en = 1'b0;
    logic [31:0]                  rd_word, word = 32'h0;
    logic [7:0]                   gap = 8'h00;
    int                           n_fail = 0, checks = 0;
    // one steady clock, never slowed or switched during writes
    always #50 sys_clk = ~sys_clk;
    flash_word_write_sequencer #(
        .PAGE_ERASE_CYC(50), .CHIP_ERASE_CYC(50)
    ) u_flash_word_write_sequencer (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .word_address_high(addr_hi),
        .word_address_low(addr_lo), .start_cmd(start_cmd), .byte_wr(byte_wr),
        .flash_write_byte_port(wr_byte), .page_lock('0), .lock_mask(lock_mask),
        .abort_clr(abort_clr), .rd_word_addr(rd_word_addr), .flash_control_status(st),
        .dma_trigger(dma_trigger), .fetch_block(fetch_block), .rd_word(rd_word));
    byte_writer_model u_byte_writer_model (.sys_clk(sys_clk), .en(en), .word(word),
        .gap(gap), .dma_trigger(dma_trigger), .byte_wr(byte_wr), .wr_byte(wr_byte));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic start(input flash_seq_pkg::start_cmd_t cmd);
        @(negedge sys_clk) start_cmd = cmd;
        @(negedge sys_clk) start_cmd = '0;
    endtask
    task automatic wait_flag(input bit want_full);
        int n;
        for (n = 0; n < 2000 && (want_full ? st.full !== 1'b1 : st.busy !== 1'b0); n++)
            @(negedge sys_clk);
        if (n == 2000) check(32'h1, 32'h0);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(negedge sys_clk) rd_word_addr = a;
        @(negedge sys_clk) check(rd_word, exp);
    endtask
    // Sends one word, waits until full rises, then stops the writer
    task automatic write_word(input logic [31:0] w);
        word = w;
        en   = 1'b1;
        start(3'b100);
        wait_flag(1'b1);
        en   = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_two_words();
        // erase the whole array before the first program
        start(3'b001);
        wait_flag(1'b0);
        rd(16'h0210, flash_seq_pkg::ERASED_WORD);
        word = 32'h12345678;
        en   = 1'b1;
        start(3'b100);
        check({st.busy, st.write}, 2'h3);
        wait_flag(1'b1);
        // Next word set while full, so the model never sees it change as it sends
        word = 32'hA5C3F00F;
        @(negedge sys_clk);
        wait_flag(1'b1);
        en   = 1'b0;
        wait_flag(1'b0);
        check({st.busy, st.write, st.timeout}, 3'h1);
        rd(16'h0210, 32'h12345678);
        rd(16'h0211, 32'hA5C3F00F);
    endtask
    task automatic test_masked_slow();
        gap = 8'h03;
        // second program of this word since its erase
        write_word(32'hFF00FF0F);
        wait_flag(1'b0);
        gap = 8'h00;
        rd(16'h0210, 32'h12005608);
    endtask
    task automatic test_locked();
        lock_mask[1] = 1'b1;
        write_word(32'h00000000);
        @(negedge sys_clk);
        check({st.busy, st.write, st.abort}, 3'h1);
        rd(16'h0210, 32'h12005608);
        @(negedge sys_clk) abort_clr = 1'b1;
        @(negedge sys_clk) abort_clr = 1'b0;
        check(st.abort, 1'b0);
        lock_mask[1] = 1'b0;
    endtask
    task automatic test_erase_then_write();
        word = 32'h0BADF00D;
        en   = 1'b1;
        start(3'b110);
        repeat (40) @(negedge sys_clk);
        check({st.busy, fetch_block, dma_trigger}, 3'h6);
        wait_flag(1'b1);
        en   = 1'b0;
        wait_flag(1'b0);
        rd(16'h0210, 32'h0BADF00D);
        rd(16'h0211, flash_seq_pkg::ERASED_WORD);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge sys_clk);
        check({st, dma_trigger}, 6'h00);
        sys_rst = 1'b0;
        test_two_words();
        test_masked_slow();
        test_locked();
        test_erase_then_write();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        end_of_test();
    end
endmodule // tb_top
